// ==== spc_regs.svh ====
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

// ****************************************
// characters
// ****************************************
`define SPC_CR          7'h0D
`define SPC_SP          7'h20
`define SPC_POLL        7'h05
`define SPC_ID_RST      7'h30

// ****************************************
// reset values and limits
// ****************************************
`define SPC_TMO_DEF     6'h02
`define SPC_TMO_MIN     6'h02
`define SPC_TMO_MAX     6'h3C
`define SPC_BAUD_2400   3'h2
`define SPC_BAUD_LAST   3'h4
`define SPC_LINE_LEN    8
`define SPC_FIFO_DEPTH  8
`define SPC_PROMPT_LEN  3'h6
`define SPC_REPLY_LEN   3'h3

// ****************************************
// timing
// ****************************************
`define SPC_CLK_HZ      20000000
`define SPC_MIN_S       60
`define SPC_CYC_PER_MIN (`SPC_CLK_HZ * `SPC_MIN_S)

`endif

// ==== spc_pkg.sv ====
package spc_pkg;

	typedef enum logic [1:0]
	{
		SPC_IDLE = 2'h0,
		SPC_ECHO = 2'h1,
		SPC_TEXT = 2'h3,
		SPC_MSG  = 2'h2
	} spc_emit_st_t;

	typedef enum logic
	{
		SPC_TXT_PROMPT = 1'h0,
		SPC_TXT_REPLY  = 1'h1
	} spc_text_t;

	typedef enum logic
	{
		SPC_CONT = 1'h0,
		SPC_STBY = 1'h1
	} spc_oper_t;

	typedef struct packed
	{
		logic       port;
		logic [7:0] data;
	} spc_txw_t;

	typedef struct packed
	{
		logic       poll_mode;
		logic       msg_port;
		logic [1:0] rs485;
	} spc_cfg_t;

endpackage : spc_pkg

// ==== spc_fifo.sv ====
`timescale 1ns/100ps

module spc_fifo #(
	parameter int W = 9,
	parameter int D = 8
) (
	input  wire logic         clk_sys_i,
	input  wire logic         sys_rst_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic      [W-1:0] out_data_o
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW-1:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
	logic [AW:0]   count, next_count;
	logic          push, pop;

	assign in_ready_o  = (count != (AW+1)'(D));
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_comb
	begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (push)
			next_wr_ptr = (wr_ptr == AW'(D-1)) ? '0 : AW'(wr_ptr + 1'b1);
		if (pop)
			next_rd_ptr = (rd_ptr == AW'(D-1)) ? '0 : AW'(rd_ptr + 1'b1);
		next_count = (AW+1)'(count + push - pop);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end
endmodule : spc_fifo

// ==== spc_idle_timer.sv ====
`timescale 1ns/100ps

module spc_idle_timer #(
	parameter int unsigned CYC_PER_MIN = 1200000000
) (
	input  wire logic       clk_sys_i,
	input  wire logic       sys_rst_i,
	input  wire logic       run_i,
	input  wire logic       kick_i,
	input  wire logic [5:0] limit_i,
	output logic            expire_o
);
	logic [30:0] sub, next_sub;
	logic [5:0]  mins, next_mins;
	logic        next_expire;

	// restarts on every received character, idles while the port is closed
	always_comb
	begin
		next_sub    = sub;
		next_mins   = mins;
		next_expire = 1'b0;
		if (!run_i || kick_i)
		begin
			next_sub  = '0;
			next_mins = '0;
		end
		else if (mins >= limit_i)
			next_expire = !expire_o;
		else if (sub == 31'(CYC_PER_MIN - 1))
		begin
			next_sub  = '0;
			next_mins = 6'(mins + 1'b1);
		end
		else
			next_sub = 31'(sub + 1'b1);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			sub      <= '0;
			mins     <= '0;
			expire_o <= 1'b0;
		end
		else
		begin
			sub      <= next_sub;
			mins     <= next_mins;
			expire_o <= next_expire;
		end
	end
endmodule : spc_idle_timer

// ==== spc_session_ctrl.sv ====
`timescale 1ns/100ps
`include "spc_regs.svh"

module spc_session_ctrl #(
	parameter int unsigned CYC_PER_MIN = `SPC_CYC_PER_MIN,
	parameter int          LINE_LEN    = `SPC_LINE_LEN,
	parameter int          FIFO_DEPTH  = `SPC_FIFO_DEPTH
) (
	input  wire logic                 clk_sys_i,
	input  wire logic                 sys_rst_i,
	input  wire logic [1:0]           rx_valid_i,
	input  wire logic [1:0][7:0]      rx_data_i,
	output logic      [1:0]           rx_ready_o,
	input  wire logic                 msg_valid_i,
	input  wire logic [6:0]           msg_char_i,
	input  wire logic                 msg_last_i,
	output logic                      msg_ready_o,
	output spc_pkg::spc_txw_t         tx_word_o,
	output logic                      tx_valid_o,
	input  wire logic                 tx_ready_i,
	input  wire logic                 mode_cmd_valid_i,
	input  wire logic                 mode_cmd_standby_i,
	input  wire logic                 start_cmd_i,
	input  wire logic                 interval_tick_i,
	input  wire logic                 cfg_wr_i,
	input  wire spc_pkg::spc_cfg_t    cfg_i,
	input  wire logic                 timeout_wr_i,
	input  wire logic [5:0]           timeout_min_i,
	input  wire logic                 id_wr_i,
	input  wire logic [6:0]           id_char_i,
	input  wire logic [1:0]           baud_wr_i,
	input  wire logic [2:0]           baud_code_i,
	output logic      [1:0]           port_open_o,
	output logic                      continuous_o,
	output logic                      wear_parts_on_o,
	output logic                      meas_start_o,
	output logic                      msg_req_o,
	output logic      [5:0]           timeout_min_o,
	output logic      [6:0]           station_identifier_o,
	output logic      [1:0][2:0]      baud_sel_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [6:0] to_upper(input logic [6:0] c);
		to_upper = (c >= 7'h61 && c <= 7'h7A) ? 7'(c - 7'h20) : c;
	endfunction : to_upper

	function automatic logic [7:0] with_par(input logic [6:0] c);
		with_par = {^c, c};
	endfunction : with_par

	function automatic logic [6:0] text_char(input spc_pkg::spc_text_t sel,
		input logic [2:0] idx);
		logic [6:0] c;
		c = 7'h3E;
		if (sel == spc_pkg::SPC_TXT_REPLY)
			case (idx)
				3'h0:    c = 7'h43;
				3'h1:    c = 7'h54;
				default: c = 7'h3A;
			endcase
		else
			case (idx)
				3'h0:    c = 7'h43;
				3'h1:    c = 7'h45;
				3'h2:    c = 7'h49;
				3'h3:    c = 7'h4C;
				3'h4:    c = 7'h4F;
				default: c = 7'h3E;
			endcase
		text_char = c;
	endfunction : text_char

	function automatic logic id_valid(input logic [6:0] c);
		id_valid = (c >= 7'h30 && c <= 7'h39) || (c >= 7'h41 && c <= 7'h5A);
	endfunction : id_valid

	// ****************************************
	// state
	// ****************************************
	logic [1:0]                 port_open, next_port_open, expire;
	logic [LINE_LEN*7-1:0]      lb [2];
	logic [LINE_LEN*7-1:0]      next_lb [2];
	logic [3:0]                 lb_len [2];
	logic [3:0]                 next_lb_len [2];
	spc_pkg::spc_emit_st_t      st, next_st;
	spc_pkg::spc_text_t         sel, next_sel;
	logic [2:0]                 idx, next_idx;
	logic [6:0]                 echo_ch, next_echo_ch;
	logic                       eport, next_eport, prompt_after, next_prompt_after;
	logic                       out_valid, next_out_valid, hold_free;
	spc_pkg::spc_txw_t          out_word, next_out_word, fifo_word;
	logic                       fifo_in_ready, fifo_out_valid, tx_load;
	logic [1:0]                 next_rx_ready;
	logic                       next_msg_ready, turn, suppress;
	logic                       take, tp, par_ok, good, is_cr, cmd_close, cmd_open, id_ok;
	logic [6:0]                 ch;
	spc_pkg::spc_oper_t         oper, next_oper;
	spc_pkg::spc_cfg_t          cfg, next_cfg;
	logic                       next_meas, next_req;
	logic [5:0]                 next_tmo;
	logic [6:0]                 next_id;
	logic [1:0][2:0]            next_baud;

	// ****************************************
	// receive decode
	// ****************************************
	// data path only
	always_comb
	begin
		take = 1'b0;
		tp   = 1'b0;
		for (int p = 0; p < 2; p++)
			if (rx_valid_i[p] && rx_ready_o[p])
			begin
				take = 1'b1;
				tp   = 1'(p);
			end
		ch = to_upper(rx_data_i[tp][6:0]);
		par_ok = ~^rx_data_i[tp];
		good   = take && par_ok;
		is_cr     = (ch == `SPC_CR);
		cmd_close = (lb_len[tp] == 4'h5) &&
			(lb[tp][34:0] == {7'h45, 7'h53, 7'h4F, 7'h4C, 7'h43});
		id_ok = cfg.rs485[tp] ? ((lb_len[tp] == 4'h6) && (lb[tp][34:28] == `SPC_SP) &&
			(lb[tp][41:35] == station_identifier_o)) : (lb_len[tp] == 4'h4);
		// only open is honoured while closed
		cmd_open = id_ok && (lb[tp][27:0] == {7'h4E, 7'h45, 7'h50, 7'h4F});
		suppress = port_open[cfg.msg_port];
	end

	// ****************************************
	// port sessions
	// ****************************************
	// identical per-line state
	always_comb
	begin
		next_port_open = port_open;
		next_lb        = lb;
		next_lb_len    = lb_len;
		for (int p = 0; p < 2; p++)
			if (expire[p])
				next_port_open[p] = 1'b0;
		if (good && is_cr)
		begin
			next_lb_len[tp] = '0;
			if (port_open[tp] && cmd_close)
				next_port_open[tp] = 1'b0;
			// refuse while the other is open
			else if (!port_open[tp] && cmd_open && !port_open[~tp])
				next_port_open[tp] = 1'b1;
		end
		else if (good && lb_len[tp] < 4'(LINE_LEN))
		begin
			next_lb[tp][7*lb_len[tp] +: 7] = ch;
			next_lb_len[tp]                 = 4'(lb_len[tp] + 1'b1);
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			port_open <= '0;
			for (int p = 0; p < 2; p++)
			begin
				lb[p]     <= '0;
				lb_len[p] <= '0;
			end
		end
		else
		begin
			port_open <= next_port_open;
			lb        <= next_lb;
			lb_len    <= next_lb_len;
		end
	end

	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_tmr
			spc_idle_timer #(.CYC_PER_MIN(CYC_PER_MIN)) u_tmr (
				.clk_sys_i (clk_sys_i),
				.sys_rst_i (sys_rst_i),
				.run_i     (port_open[g]),
				.kick_i    (take && (tp == 1'(g))),
				.limit_i   (timeout_min_o),
				.expire_o  (expire[g])
			);
		end
	endgenerate

	// ****************************************
	// response emitter
	// ****************************************
	always_comb
	begin
		next_st           = st;
		next_sel          = sel;
		next_idx          = idx;
		next_echo_ch      = echo_ch;
		next_eport        = eport;
		next_prompt_after = prompt_after;
		hold_free         = !out_valid || fifo_in_ready;
		next_out_valid    = out_valid && !fifo_in_ready;
		next_out_word     = out_word;
		case (st)
			spc_pkg::SPC_IDLE:
				if (good && port_open[tp])
				begin
					next_st           = spc_pkg::SPC_ECHO;
					next_echo_ch      = ch;
					next_eport        = tp;
					next_prompt_after = is_cr && !cmd_close;
				end
				else if (good && is_cr)
				begin
					next_st    = spc_pkg::SPC_TEXT;
					next_eport = tp;
					next_idx   = '0;
					next_sel   = (cmd_open && !port_open[~tp]) ? spc_pkg::SPC_TXT_PROMPT
						: spc_pkg::SPC_TXT_REPLY;
				end
				// message stream only to a closed message port
				else if (!take && msg_valid_i && !suppress)
					next_st = spc_pkg::SPC_MSG;
			spc_pkg::SPC_ECHO:
				if (hold_free)
				begin
					next_out_valid = 1'b1;
					next_out_word  = '{port: eport, data: with_par(echo_ch)};
					next_idx       = '0;
					next_sel       = spc_pkg::SPC_TXT_PROMPT;
					next_st        = prompt_after ? spc_pkg::SPC_TEXT : spc_pkg::SPC_IDLE;
				end
			spc_pkg::SPC_TEXT:
				if (hold_free)
				begin
					next_out_valid = 1'b1;
					next_out_word  = '{port: eport, data: with_par(text_char(sel, idx))};
					next_idx       = 3'(idx + 1'b1);
					if (idx == ((sel == spc_pkg::SPC_TXT_PROMPT) ? `SPC_PROMPT_LEN - 3'h1
						: `SPC_REPLY_LEN - 3'h1))
						next_st = spc_pkg::SPC_IDLE;
				end
			spc_pkg::SPC_MSG:
				if (msg_valid_i && msg_ready_o)
				begin
					next_out_valid = 1'b1;
					next_out_word  = '{port: cfg.msg_port, data: with_par(to_upper(msg_char_i))};
					if (msg_last_i)
						next_st = spc_pkg::SPC_IDLE;
				end
			default:
				next_st = spc_pkg::SPC_IDLE;
		endcase
		// one line offered per cycle, so two commands never collide
		for (int p = 0; p < 2; p++)
			next_rx_ready[p] = (next_st == spc_pkg::SPC_IDLE) && (turn == 1'(p));
		// messages meant for an open port are drained and dropped
		next_msg_ready = ((next_st == spc_pkg::SPC_MSG) && !next_out_valid) ||
			((next_st == spc_pkg::SPC_IDLE) && suppress);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			st           <= spc_pkg::SPC_IDLE;
			sel          <= spc_pkg::SPC_TXT_PROMPT;
			idx          <= '0;
			echo_ch      <= '0;
			eport        <= 1'b0;
			prompt_after <= 1'b0;
			out_valid    <= 1'b0;
			out_word     <= '0;
			rx_ready_o   <= '0;
			msg_ready_o  <= 1'b0;
			turn         <= 1'b0;
		end
		else
		begin
			st           <= next_st;
			sel          <= next_sel;
			idx          <= next_idx;
			echo_ch      <= next_echo_ch;
			eport        <= next_eport;
			prompt_after <= next_prompt_after;
			out_valid    <= next_out_valid;
			out_word     <= next_out_word;
			rx_ready_o   <= next_rx_ready;
			msg_ready_o  <= next_msg_ready;
			turn         <= !turn;
		end
	end

	// ****************************************
	// transmit buffer and output stage
	// ****************************************
	assign tx_load = !tx_valid_o || tx_ready_i;

	spc_fifo #(.W($bits(spc_pkg::spc_txw_t)), .D(FIFO_DEPTH)) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.sys_rst_i   (sys_rst_i),
		.in_valid_i  (out_valid),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (out_word),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (tx_load),
		.out_data_o  (fifo_word)
	);

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			tx_valid_o <= 1'b0;
			tx_word_o  <= '0;
		end
		else if (tx_load)
		begin
			tx_valid_o <= fifo_out_valid;
			tx_word_o  <= fifo_word;
		end
	end

	// ****************************************
	// operation mode and configuration
	// ****************************************
	always_comb
	begin
		next_oper = oper;
		if (mode_cmd_valid_i)
			next_oper = mode_cmd_standby_i ? spc_pkg::SPC_STBY : spc_pkg::SPC_CONT;
		// interval drives continuous, start drives standby
		next_meas = (oper == spc_pkg::SPC_CONT) ? interval_tick_i : start_cmd_i;
		// autosend follows measurement, polling follows the poll character
		next_req  = cfg.poll_mode ? (good && (ch == `SPC_POLL) && !port_open[tp] &&
			(tp == cfg.msg_port)) : meas_start_o;
		next_cfg  = cfg_wr_i ? cfg_i : cfg;
		next_tmo  = timeout_min_o;
		if (timeout_wr_i)
			next_tmo = (timeout_min_i < `SPC_TMO_MIN) ? `SPC_TMO_MIN :
				(timeout_min_i > `SPC_TMO_MAX) ? `SPC_TMO_MAX : timeout_min_i;
		next_id = station_identifier_o;
		if (id_wr_i && id_valid(to_upper(id_char_i)))
			next_id = to_upper(id_char_i);
		next_baud = baud_sel_o;
		for (int p = 0; p < 2; p++)
			if (baud_wr_i[p] && baud_code_i <= `SPC_BAUD_LAST)
				next_baud[p] = baud_code_i;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			oper                 <= spc_pkg::SPC_CONT;
			meas_start_o         <= 1'b0;
			msg_req_o            <= 1'b0;
			cfg                  <= '0;
			timeout_min_o        <= `SPC_TMO_DEF;
			station_identifier_o <= `SPC_ID_RST;
			baud_sel_o           <= {`SPC_BAUD_2400, `SPC_BAUD_2400};
			continuous_o         <= 1'b1;
			wear_parts_on_o      <= 1'b1;
			port_open_o          <= '0;
		end
		else
		begin
			oper                 <= next_oper;
			meas_start_o         <= next_meas;
			msg_req_o            <= next_req;
			cfg                  <= next_cfg;
			timeout_min_o        <= next_tmo;
			station_identifier_o <= next_id;
			baud_sel_o           <= next_baud;
			continuous_o         <= (next_oper == spc_pkg::SPC_CONT);
			wear_parts_on_o      <= (next_oper == spc_pkg::SPC_CONT);
			port_open_o          <= next_port_open;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence s_open_try;
		good && is_cr && !port_open[tp] && cmd_open;
	endsequence

	sequence s_close_cmd;
		good && is_cr && port_open[tp] && cmd_close;
	endsequence

	AST_MODE_SWITCH: assert property (mode_cmd_valid_i |=> ##1
		continuous_o == !$past(mode_cmd_standby_i, 2)) else $error("mode not switched");
	AST_STBY_CYCLE: assert property (oper == spc_pkg::SPC_STBY |=>
		meas_start_o == $past(start_cmd_i)) else $error("standby start mismatch");
	AST_ONE_OPEN: assert property (port_open_o != 2'h3)
		else $error("two ports open");
	AST_TX_PARITY: assert property (tx_valid_o |-> !(^tx_word_o.data))
		else $error("bad transmit parity");
	AST_TX_UPPER: assert property (tx_valid_o |->
		!(tx_word_o.data[6:0] >= 7'h61 && tx_word_o.data[6:0] <= 7'h7A))
		else $error("lower case sent");
	AST_OPEN_OK: assert property (s_open_try ##0 !port_open[~tp] ##0 !expire[tp]
		|=> port_open[$past(tp)]) else $error("open refused");
	AST_OPEN_REFUSE: assert property (s_open_try ##0 port_open[~tp]
		|=> !port_open[$past(tp)]) else $error("second port opened");
	AST_CLOSE: assert property (s_close_cmd |=> !port_open[$past(tp)])
		else $error("close ignored");
	AST_TMO_CLOSE: assert property ((expire & port_open) != 2'h0 |=>
		(port_open & $past(expire)) == 2'h0) else $error("time-out did not close");
	AST_MSG_CLOSED: assert property (st == spc_pkg::SPC_MSG |-> !suppress)
		else $error("message to open port");
	AST_ECHO: assert property (good && port_open[tp] && st == spc_pkg::SPC_IDLE
		|=> st == spc_pkg::SPC_ECHO ##0 echo_ch == $past(ch)) else $error("no echo");
	AST_TMO_RANGE: assert property (timeout_min_o >= `SPC_TMO_MIN &&
		timeout_min_o <= `SPC_TMO_MAX) else $error("time-out out of range");
endmodule : spc_session_ctrl

// ==== spc_term_model.sv ====
`timescale 1ns/100ps

// ****
// terminal on both serial lines
// ****
module spc_term_model (
	input  wire logic            clk_sys_i,
	input  wire logic            slow_i,
	input  wire logic [1:0]      rx_ready_i,
	output logic      [1:0]      rx_valid_o,
	output logic      [1:0][7:0] rx_data_o,
	output logic                 tx_ready_o
);
	logic [2:0] cnt;

	initial
	begin
		rx_valid_o = 2'h0;
		rx_data_o = 16'h0000;
		tx_ready_o = 1'h1;
		cnt = 3'h0;
	end

	// slow mode is ready only one cycle in eight
	always @(posedge clk_sys_i)
	begin
		cnt <= cnt + 3'h1;
		tx_ready_o <= !slow_i || (cnt == 3'h7);
	end

	task automatic send(input logic p, input logic [6:0] c);
		@(posedge clk_sys_i);
		rx_valid_o[p] <= 1'h1;
		rx_data_o[p] <= {^c, c};
		do
			@(posedge clk_sys_i);
		while (!rx_ready_i[p]);
		rx_valid_o[p] <= 1'h0;
		// released line must not look like a stale char
		rx_data_o[p] <= ~{^c, c};
	endtask : send
endmodule : spc_term_model

// ==== tb.sv ====
`timescale 1ns/100ps

module tb;
	localparam int unsigned CPM = 100;
	logic clk_sys_i = 1'h0, sys_rst_i = 1'h1, msg_valid_i = 1'h0, msg_last_i = 1'h0;
	logic mode_cmd_valid_i = 1'h0, mode_cmd_standby_i = 1'h0, start_cmd_i = 1'h0;
	logic interval_tick_i = 1'h0, cfg_wr_i = 1'h0, timeout_wr_i = 1'h0, id_wr_i = 1'h0;
	logic slow = 1'h0;
	logic [1:0]        baud_wr_i = 2'h0;
	logic [6:0]        msg_char_i = 7'h00, id_char_i = 7'h00;
	logic [2:0]        baud_code_i = 3'h0;
	logic [5:0]        timeout_min_i = 6'h00;
	spc_pkg::spc_cfg_t cfg_i = 4'h0;
	logic              msg_ready_o, tx_valid_o, tx_ready_i, continuous_o, wear_parts_on_o;
	logic              meas_start_o, msg_req_o;
	logic [1:0]        rx_valid_i, rx_ready_o, port_open_o;
	logic [1:0][7:0]   rx_data_i;
	logic [6:0]        station_identifier_o, eid, f;
	logic [5:0]        timeout_min_o;
	logic [1:0][2:0]   baud_sel_o, eb;
	spc_pkg::spc_txw_t tx_word_o;
	logic [31:0]       v;
	logic [31:0]       corner [4] = '{32'h00137A00, 32'h00152F3D, 32'h0002413C, 32'h000B3901};
	logic [8:0]        txq [$];
	int                errors, total_checks, nms, nrq, cyc, t0, b;
	int                seed = 72071;
	// expected prompt and closed reply, spelled as character codes
	string             prompt_s = "\103\105\111\114\117\076";
	string             reply_s = "\103\124\072";

	spc_session_ctrl #(.CYC_PER_MIN(CPM)) uut (.clk_sys_i, .sys_rst_i, .rx_valid_i, .rx_data_i,
		.rx_ready_o, .msg_valid_i, .msg_char_i, .msg_last_i, .msg_ready_o, .tx_word_o,
		.tx_valid_o, .tx_ready_i, .mode_cmd_valid_i, .mode_cmd_standby_i, .start_cmd_i,
		.interval_tick_i, .cfg_wr_i, .cfg_i, .timeout_wr_i, .timeout_min_i, .id_wr_i, .id_char_i,
		.baud_wr_i, .baud_code_i, .port_open_o, .continuous_o, .wear_parts_on_o, .meas_start_o,
		.msg_req_o, .timeout_min_o, .station_identifier_o, .baud_sel_o);
	spc_term_model term (.clk_sys_i, .slow_i(slow), .rx_ready_i(rx_ready_o),
		.rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .tx_ready_o(tx_ready_i));

	always #25 clk_sys_i = ~clk_sys_i;

	// ****
	// monitors and checks
	// ****
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (tx_valid_o === 1'h1 && tx_ready_i === 1'h1)
			txq.push_back(tx_word_o);
		if (meas_start_o === 1'h1)
			nms++;
		if (msg_req_o === 1'h1)
			nrq++;
		if (cyc == 50000)
		begin
			errors++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		$display("errors %0d checks %0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [6:0] fold(input logic [6:0] c);
		return (c >= 7'h61 && c <= 7'h7A) ? c - 7'h20 : c;
	endfunction : fold

	function automatic logic [5:0] clampt(input logic [5:0] m);
		return (m < 6'h02) ? 6'h02 : (m > 6'h3C) ? 6'h3C : m;
	endfunction : clampt

	task automatic say(input logic p, input string s);
		logic [7:0] c;
		for (int i = 0; i < s.len(); i++)
		begin
			c = s[i];
			term.send(p, c[6:0]);
		end
	endtask : say

	task automatic msg(input string s);
		logic [7:0] c;
		for (int i = 0; i < s.len(); i++)
		begin
			c = s[i];
			msg_valid_i <= 1'h1;
			msg_char_i <= c[6:0];
			msg_last_i <= (i == s.len() - 1);
			do
				@(posedge clk_sys_i);
			while (!msg_ready_o);
		end
		msg_valid_i <= 1'h0;
	endtask : msg

	// exact output string, then silence; parity even, letters upper
	task automatic expect_str(input logic p, input string s);
		int n;
		logic [7:0] c;
		n = 0;
		while (txq.size() < s.len() && n < 400)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		repeat (40) @(posedge clk_sys_i);
		chk(txq.size(), s.len());
		for (int i = 0; i < s.len() && i < txq.size(); i++)
		begin
			c = s[i];
			chk(txq[i], {p, ^c[6:0], c[6:0]});
		end
		txq.delete();
	endtask : expect_str

	task automatic setcfg(input logic [3:0] x);
		cfg_i <= x;
		cfg_wr_i <= 1'h1;
		@(posedge clk_sys_i);
		cfg_wr_i <= 1'h0;
	endtask : setcfg

	// the ignored trigger first, then the one that counts
	task automatic mode_run(input logic sb);
		int a;
		a = nms;
		b = nrq;
		mode_cmd_valid_i <= 1'h1;
		mode_cmd_standby_i <= sb;
		@(posedge clk_sys_i);
		mode_cmd_valid_i <= 1'h0;
		repeat (2) @(posedge clk_sys_i);
		chk({continuous_o, wear_parts_on_o}, {!sb, !sb});
		interval_tick_i <= sb;
		start_cmd_i <= !sb;
		@(posedge clk_sys_i);
		interval_tick_i <= 1'h0;
		start_cmd_i <= 1'h0;
		repeat (4) @(posedge clk_sys_i);
		chk(nms - a, 0);
		interval_tick_i <= !sb;
		start_cmd_i <= sb;
		@(posedge clk_sys_i);
		interval_tick_i <= 1'h0;
		start_cmd_i <= 1'h0;
		repeat (5) @(posedge clk_sys_i);
		chk(nms - a, 1);
		chk(nrq - b, 1);
	endtask : mode_run

	// ****
	// main sequence
	// ****
	initial
	begin
		eid = 7'h30;
		eb = 6'h12;
		repeat (6) @(posedge clk_sys_i);
		sys_rst_i <= 1'h0;
		repeat (2) @(posedge clk_sys_i);
		chk(port_open_o, 2'h0);
		chk({continuous_o, wear_parts_on_o}, 2'h3);
		chk(timeout_min_o, 6'h02);
		chk(station_identifier_o, 7'h30);
		chk(baud_sel_o, 6'h12);
		say(1'h0, "x\015");
		expect_str(1'h0, reply_s);
		say(1'h0, "open");
		chk(port_open_o, 2'h0);
		say(1'h0, "\015");
		expect_str(1'h0, prompt_s);
		say(1'h1, "OPEN\015");
		expect_str(1'h1, reply_s);
		chk(port_open_o, 2'h1);
		slow <= 1'h1;
		say(1'h0, "a\015");
		expect_str(1'h0, {"A\015", prompt_s});
		msg("m");
		expect_str(1'h0, "");
		say(1'h0, "Close\015");
		expect_str(1'h0, "CLOSE\015");
		chk(port_open_o, 2'h0);
		msg("ab");
		expect_str(1'h0, "AB");
		setcfg(4'h4);
		msg("c");
		expect_str(1'h1, "C");
		mode_run(1'h1);
		mode_run(1'h0);
		setcfg(4'h5);
		say(1'h0, "open 5\015");
		expect_str(1'h0, reply_s);
		say(1'h0, "open 0\015");
		expect_str(1'h0, prompt_s);
		say(1'h0, "close\015");
		expect_str(1'h0, "CLOSE\015");
		// corner values first, then random ones
		for (int k = 0; k < 16; k++)
		begin
			v = (k < 4) ? corner[k] : $random(seed);
			timeout_wr_i <= 1'h1;
			timeout_min_i <= v[5:0];
			id_wr_i <= 1'h1;
			id_char_i <= v[14:8];
			baud_wr_i <= v[17:16];
			baud_code_i <= v[20:18];
			@(posedge clk_sys_i);
			timeout_wr_i <= 1'h0;
			id_wr_i <= 1'h0;
			baud_wr_i <= 2'h0;
			repeat (2) @(posedge clk_sys_i);
			f = fold(v[14:8]);
			if ((f >= 7'h30 && f <= 7'h39) || (f >= 7'h41 && f <= 7'h5A))
				eid = f;
			for (int l = 0; l < 2; l++)
				if (v[16 + l] && v[20:18] <= 3'h4)
					eb[l] = v[20:18];
			chk(timeout_min_o, clampt(v[5:0]));
			chk(station_identifier_o, eid);
			chk(baud_sel_o, eb);
		end
		timeout_wr_i <= 1'h1;
		timeout_min_i <= 6'h03;
		@(posedge clk_sys_i);
		timeout_wr_i <= 1'h0;
		say(1'h1, "open\015");
		t0 = cyc;
		expect_str(1'h1, prompt_s);
		while (port_open_o[1] !== 1'h0 && cyc - t0 < 400)
			@(posedge clk_sys_i);
		chk(cyc - t0 >= 295 && cyc - t0 <= 305, 1'h1);
		setcfg(4'hC);
		b = nrq;
		term.send(1'h1, 7'h05);
		repeat (6) @(posedge clk_sys_i);
		chk(nrq - b, 1);
		end_of_test();
	end
endmodule : tb
